// File: verilog/ttc_top.v
// Trail trace controller: transmit insertion, receive extraction and
// identifier supervision, with registers on an AHB-Lite slave port.
// Assumes one clock for bus and line side; line strobes come from framer
// logic on this clock, so they are used without synchronisers.
//
// Summary of operation
// - Reorder off: stored bit 7 sent first.
// - Reorder on: stored bit 0 sent first.
// - Insertion: first bit one byte0, zero others.
// - Transmit inversion after reorder and insertion.
// - Transmit idle sends all zeros.
// - Receive inversion before all receive processing.
// - Align: find one, then fifteen zeros.
// - Alignment off: store from any byte.
// - Store sequentially, aligned byte goes first.
// - Five identical nonzero new ids update receive.
// - Idle on five zeros; clears on five nonzero/unstable.
// - Unstable after eight unmatched; clears likewise.
// - Compare seven data bits; flag any mismatch.
// - Comparison switchable, off without receive alignment.
// - No mismatch until first receive update.
// - Programmable sixteen-byte expected identifier.
// - Receive reorder off: first bit to bit7.
// - Receive reorder on: first bit to bit0.
// - Current, receive, expected identifiers readable.
// - Alarms force received trace data ones.
// - Transmit storage sixteen bytes, reset untouched.
//
// Design decisions made here: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`include "ttc_consts.vh"

module ttc_top (
  input wire clk,
  input wire rstn,
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  input wire tx_bit_req,
  output wire tx_bit,
  input wire rx_bit_vld,
  input wire rx_bit_first,
  input wire rx_bit,
  input wire rx_line_alarm,
  output wire trace_idle,
  output wire trace_unstable_cond,
  output wire trace_mismatch_cond
);

  localparam ST_HUNT = 1'b0;  // Looking for an alignment one.
  localparam ST_LOCK = 1'b1;  // Walking a located identifier.

  // Swap bit order within a byte; used on both directions.
  function [7:0] rev8;
    input [7:0] d;
    integer k;
    begin
      for (k = 0; k < 8; k = k + 1) begin
        rev8[k] = d[7 - k];
      end
    end
  endfunction

  // Bus side state.
  reg dp_wr_r;          // A write is in its data phase.
  reg dp_rd_r;          // A read is in its data phase.
  reg rd_ph2_r;         // The read data has been registered.
  reg [11:0] addr_r;    // Address captured in the address phase.
  reg [`TTC_CTRL_W-1:0] ctrl_r; // Software control bits.
  reg change_r;         // Sticky receive identifier change flag.

  // Identifier storage, byte n at bits 8n+7:8n.
  reg [127:0] tx_id_r;  // Transmit identifier, not reset.
  reg [127:0] cur_id_r; // Most recently received identifier.
  reg [127:0] rcv_id_r; // Accepted receive identifier.
  reg [127:0] exp_id_r; // Expected identifier.

  // Transmit path state.
  reg [3:0] tx_idx_r;   // Byte of the identifier being sent.
  wire tx_done;
  reg [7:0] tx_sig;     // Byte in send order, bit 7 first.

  // Receive path state.
  wire [7:0] rx_sig;    // Byte in arrival order, bit 7 first.
  wire rx_vld;
  wire [7:0] rx_sto;    // Byte in storage order.
  reg st_r;             // Alignment state.
  reg [3:0] rx_idx_r;   // Storage position of the next byte.
  reg acc_cur_r;        // Bytes so far match the current identifier.
  reg acc_rcv_r;        // Bytes so far match the receive identifier.
  reg acc_zero_r;       // Bytes so far are all zero.
  reg [2:0] rep_r;      // Consecutive identical identifiers.
  reg [2:0] zcnt_r;     // Consecutive all-zero identifiers.
  reg [2:0] nzcnt_r;    // Consecutive nonzero identifiers.
  reg [3:0] miss_r;     // Consecutive identifiers matching neither.
  reg idle_r;
  reg unst_r;
  reg mism_r;
  reg rcv_valid_r;      // Receive identifier has been loaded once.

  // Combinational receive decisions.
  reg take;             // Store this byte.
  reg restart;          // This byte opens a new identifier.
  reg [3:0] pos;        // Where it goes.
  reg st_nxt;
  // Next values of the repetition counters at an identifier's end.
  wire [2:0] rep_nxt;
  wire [2:0] z_nxt;
  wire [2:0] nz_nxt;
  wire [3:0] miss_nxt;
  wire upd;
  wire idle_set;
  wire unst_set;
  wire nz_clr;
  wire b_cur;
  wire b_rcv;
  wire b_zero;
  wire f_cur;
  wire f_rcv;
  wire f_zero;
  wire id_done;

  // Bus transfer accepted in its address phase.
  wire acc_xfer;
  wire [2:0] rg;
  wire [3:0] bi;
  wire [7:0] cmp_mask;
  wire [15:0] byte_diff;
  reg [31:0] rd_mux;

  assign acc_xfer = hsel & hready & htrans[1];
  assign rg = addr_r[8:6];
  assign bi = addr_r[5:2];
  // Reads take one wait state so a write just before is already stored.
  assign hreadyout = ~(dp_rd_r & ~rd_ph2_r);
  assign hresp = 1'b0;

  // Capture the address phase and pace the data phase.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dp_wr_r <= 1'b0;
      dp_rd_r <= 1'b0;
      rd_ph2_r <= 1'b0;
      addr_r <= 12'h000;
    end else begin
      if (dp_rd_r & ~rd_ph2_r) begin
        rd_ph2_r <= 1'b1;
      end else begin
        rd_ph2_r <= 1'b0;
        dp_wr_r <= acc_xfer & hwrite;
        dp_rd_r <= acc_xfer & ~hwrite;
        if (acc_xfer) begin
          addr_r <= haddr;
        end
      end
    end
  end

  // Read multiplexer; unmapped words read as zero.
  always @* begin
    rd_mux = 32'h00000000;
    case (rg)
      `TTC_RG_CSR: begin
        if (addr_r[5:0] == `TTC_A_CTRL) begin
          rd_mux[`TTC_CTRL_W-1:0] = ctrl_r;
        end else if (addr_r[5:0] == `TTC_A_STAT) begin
          rd_mux[`TTC_S_IDLE] = idle_r;
          rd_mux[`TTC_S_UNSTABLE] = unst_r;
          rd_mux[`TTC_S_MISMATCH] = mism_r;
          rd_mux[`TTC_S_RCV_VALID] = rcv_valid_r;
          rd_mux[`TTC_S_ALIGNED] = st_r & ctrl_r[`TTC_C_RX_ALIGN];
          rd_mux[`TTC_S_CHANGE] = change_r;
        end
      end
      `TTC_RG_TX: rd_mux[7:0] = tx_id_r[{bi, 3'h0} +: 8];
      `TTC_RG_CUR: rd_mux[7:0] = cur_id_r[{bi, 3'h0} +: 8];
      `TTC_RG_RCV: rd_mux[7:0] = rcv_id_r[{bi, 3'h0} +: 8];
      `TTC_RG_EXP: rd_mux[7:0] = exp_id_r[{bi, 3'h0} +: 8];
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Register the read data at the end of the wait state so it stands for the completing cycle.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hrdata <= 32'h00000000;
    end else if (dp_rd_r & ~rd_ph2_r) begin
      hrdata <= rd_mux;
    end
  end

  // Control word, expected identifier and change flag writes.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= `TTC_CTRL_RST;
      exp_id_r <= `TTC_ID_RST;
      change_r <= 1'b0;
    end else begin
      if (dp_wr_r && rg == `TTC_RG_CSR && addr_r[5:0] == `TTC_A_CTRL) begin
        ctrl_r <= hwdata[`TTC_CTRL_W-1:0];
      end
      if (dp_wr_r && rg == `TTC_RG_EXP) begin
        exp_id_r[{bi, 3'h0} +: 8] <= hwdata[7:0];
      end
      // Writing one clears the change flag, but a new update wins.
      if (upd) begin
        change_r <= 1'b1;
      end else if (dp_wr_r && rg == `TTC_RG_CSR &&
                   addr_r[5:0] == `TTC_A_STAT &&
                   hwdata[`TTC_S_CHANGE]) begin
        change_r <= 1'b0;
      end
    end
  end

  // Transmit identifier storage keeps its contents through reset.
  always @(posedge clk) begin
    if (dp_wr_r && rg == `TTC_RG_TX) begin
      tx_id_r[{bi, 3'h0} +: 8] <= hwdata[7:0];
    end
  end

  // Prepare the outgoing byte in send order.
  always @* begin
    tx_sig = tx_id_r[{tx_idx_r, 3'h0} +: 8];
    if (ctrl_r[`TTC_C_TX_REORD]) begin
      tx_sig = rev8(tx_sig);
    end // Otherwise stored bit 7 goes first.
    if (ctrl_r[`TTC_C_TX_ALIGN]) begin
      tx_sig[7] = (tx_idx_r == 4'h0);
    end
    if (ctrl_r[`TTC_C_TX_INV]) begin
      tx_sig = ~tx_sig;
    end
    if (ctrl_r[`TTC_C_TX_IDLE]) begin
      tx_sig = 8'h00;
    end
  end

  // Step through the sixteen transmit bytes, wrapping after the last.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_idx_r <= 4'h0;
    end else if (tx_done) begin
      tx_idx_r <= tx_idx_r + 4'h1;
    end
  end

  ttc_tx_ser u_tx_ser (
    .clk(clk),
    .rstn(rstn),
    .bit_req(tx_bit_req),
    .byte_in(tx_sig),
    .bit_out(tx_bit),
    .byte_done(tx_done)
  );

  ttc_rx_deser u_rx_deser (
    .clk(clk),
    .rstn(rstn),
    .bit_vld(rx_bit_vld),
    .bit_first(rx_bit_first),
    .bit_in(rx_bit),
    .invert(ctrl_r[`TTC_C_RX_INV]),
    .alarm(rx_line_alarm),
    .byte_out(rx_sig),
    .byte_vld(rx_vld)
  );

  // Storage order: reordering moves the first received bit to bit 0.
  assign rx_sto = ctrl_r[`TTC_C_RX_REORD] ? rev8(rx_sig) : rx_sig;

  // Alignment search: decide whether and where a byte is stored.
  always @* begin
    take = 1'b0;
    restart = 1'b0;
    st_nxt = st_r;
    if (!ctrl_r[`TTC_C_RX_ALIGN]) begin
      take = rx_vld;
      st_nxt = ST_HUNT;
    end else if (rx_vld) begin
      case (st_r)
        ST_HUNT: begin
          if (rx_sig[7]) begin
            take = 1'b1;
            restart = 1'b1;
            st_nxt = ST_LOCK;
          end
        end
        ST_LOCK: begin
          if (rx_sig[7] == (rx_idx_r == 4'h0)) begin
            take = 1'b1;
          end else if (rx_sig[7]) begin
            // An early one is taken as the start of a new identifier.
            take = 1'b1;
            restart = 1'b1;
          end else begin
            st_nxt = ST_HUNT;
          end
        end
        default: st_nxt = ST_HUNT;
      endcase
    end
    pos = restart ? 4'h0 : rx_idx_r;
  end

  // Per-byte and whole-identifier comparisons, folded as bytes arrive.
  assign b_cur = (rx_sto == cur_id_r[{pos, 3'h0} +: 8]);
  assign b_rcv = rcv_valid_r & (rx_sto == rcv_id_r[{pos, 3'h0} +: 8]);
  assign b_zero = (rx_sto == 8'h00);
  assign f_cur = b_cur & ((pos == 4'h0) | acc_cur_r);
  assign f_rcv = b_rcv & ((pos == 4'h0) | acc_rcv_r);
  assign f_zero = b_zero & ((pos == 4'h0) | acc_zero_r);
  assign id_done = take & (pos == `TTC_LAST_IDX);

  // Counter decisions, made as the sixteenth byte is stored.
  assign rep_nxt = f_cur ? ((rep_r == `TTC_REP_UPDATE) ? rep_r :
                   rep_r + 3'h1) : 3'h1;
  assign z_nxt = f_zero ? ((zcnt_r == `TTC_ZERO_IDLE) ? zcnt_r :
                 zcnt_r + 3'h1) : 3'h0;
  assign nz_nxt = f_zero ? 3'h0 : ((nzcnt_r == `TTC_NZ_CLEAR) ? nzcnt_r :
                  nzcnt_r + 3'h1);
  assign miss_nxt = (f_cur | f_rcv) ? 4'h0 :
                    ((miss_r == `TTC_MISS_UNST) ? miss_r : miss_r + 4'h1);
  assign upd = id_done & ~f_zero & ~f_rcv &
               (rep_nxt == `TTC_REP_UPDATE);
  assign idle_set = id_done & (z_nxt == `TTC_ZERO_IDLE);
  assign unst_set = id_done & (miss_nxt == `TTC_MISS_UNST);
  assign nz_clr = id_done & (nz_nxt == `TTC_NZ_CLEAR);

  // Receive extraction, current identifier tracking and supervision.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= ST_HUNT;
      rx_idx_r <= 4'h0;
      acc_cur_r <= 1'b0;
      acc_rcv_r <= 1'b0;
      acc_zero_r <= 1'b0;
      rep_r <= 3'h0;
      zcnt_r <= 3'h0;
      nzcnt_r <= 3'h0;
      miss_r <= 4'h0;
      idle_r <= 1'b0;
      unst_r <= 1'b0;
      rcv_valid_r <= 1'b0;
      cur_id_r <= `TTC_ID_RST;
      rcv_id_r <= `TTC_ID_RST;
    end else begin
      st_r <= st_nxt;
      if (take) begin
        cur_id_r[{pos, 3'h0} +: 8] <= rx_sto;
        rx_idx_r <= pos + 4'h1;
        acc_cur_r <= f_cur;
        acc_rcv_r <= f_rcv;
        acc_zero_r <= f_zero;
      end else if (st_nxt == ST_HUNT && ctrl_r[`TTC_C_RX_ALIGN]) begin
        rx_idx_r <= 4'h0;
      end
      if (id_done) begin
        rep_r <= rep_nxt;
        zcnt_r <= z_nxt;
        nzcnt_r <= nz_nxt;
        miss_r <= miss_nxt;
        // Idle declaration wins when both decisions fall together.
        if (idle_set) begin
          idle_r <= 1'b1;
          unst_r <= 1'b0;
        end else if (unst_set) begin
          unst_r <= 1'b1;
          idle_r <= 1'b0;
        end else if (nz_clr) begin
          idle_r <= 1'b0;
          unst_r <= 1'b0;
        end
      end
      if (upd) begin
        // The last byte is still being written into the current copy.
        rcv_id_r <= {rx_sto, cur_id_r[119:0]};
        rcv_valid_r <= 1'b1;
      end
    end
  end

  // Masked byte comparison; the alignment bit moves with reordering.
  assign cmp_mask = ctrl_r[`TTC_C_RX_REORD] ? 8'hfe : 8'h7f;
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_cmp
      assign byte_diff[gi] = |((rcv_id_r[gi*8 +: 8] ^ exp_id_r[gi*8 +: 8])
                               & cmp_mask);
    end
  endgenerate

  // Mismatch follows the comparison while it is enabled and meaningful.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mism_r <= 1'b0;
    end else begin
      mism_r <= ctrl_r[`TTC_C_EXP_CMP] & ctrl_r[`TTC_C_RX_ALIGN] &
                rcv_valid_r & (|byte_diff);
    end
  end

  assign trace_idle = idle_r;
  assign trace_unstable_cond = unst_r;
  assign trace_mismatch_cond = mism_r;

endmodule // ttc_top

// File: verilog/ttc_consts.vh
// Constants of the trail trace controller: register offsets, control and
// status field positions, reset values and identifier counts.
// Included by bare name; holds definitions only.
`ifndef TTC_CONSTS_VH
`define TTC_CONSTS_VH

// Byte offsets of the control and status words inside the block.
`define TTC_A_CTRL 12'h000
`define TTC_A_STAT 12'h004
// Region selects taken from address bits 8:6: the control words, then one per 16-byte identifier.
`define TTC_RG_CSR 3'h0
`define TTC_RG_TX 3'h1
`define TTC_RG_CUR 3'h2
`define TTC_RG_RCV 3'h3
`define TTC_RG_EXP 3'h4

// Control word field positions.
`define TTC_C_TX_REORD 0
`define TTC_C_TX_ALIGN 1
`define TTC_C_TX_INV 2
`define TTC_C_TX_IDLE 3
`define TTC_C_RX_INV 4
`define TTC_C_RX_ALIGN 5
`define TTC_C_RX_REORD 6
`define TTC_C_EXP_CMP 7
`define TTC_CTRL_W 8
`define TTC_CTRL_RST 8'h00

// Status word field positions.
`define TTC_S_IDLE 0
`define TTC_S_UNSTABLE 1
`define TTC_S_MISMATCH 2
`define TTC_S_RCV_VALID 3
`define TTC_S_ALIGNED 4
`define TTC_S_CHANGE 5

// Identifier length and decision counts.
`define TTC_LAST_IDX 4'hf
`define TTC_REP_UPDATE 3'h5
`define TTC_NZ_CLEAR 3'h5
`define TTC_ZERO_IDLE 3'h5
`define TTC_MISS_UNST 4'h8
`define TTC_ID_RST 128'h0

`endif

// File: verilog/ttc_tx_ser.v
// Transmit serializer of the trail trace controller.
// Assumes the framer pulses bit_req once per trace bit it wants to send.
`timescale 1ns/1ps

module ttc_tx_ser (
  input wire clk,
  input wire rstn,
  input wire bit_req,
  input wire [7:0] byte_in,
  output reg bit_out,
  output wire byte_done
);

  // Position of the next bit to send; 0 is the first bit of a byte.
  reg [2:0] cnt_r;

  // The last bit of a byte has been handed out, so the caller moves on.
  assign byte_done = bit_req & (cnt_r == 3'h7);

  // Bits leave first-bit-first, which is bit 7 of the prepared byte.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 3'h0;
      bit_out <= 1'b0;
    end else if (bit_req) begin
      bit_out <= byte_in[3'h7 - cnt_r];
      cnt_r <= cnt_r + 3'h1;
    end
  end

endmodule // ttc_tx_ser

// File: verilog/ttc_rx_deser.v
// Receive deserializer of the trail trace controller.
// Assumes the framer marks the first bit of each trace byte with bit_first.
`timescale 1ns/1ps

module ttc_rx_deser (
  input wire clk,
  input wire rstn,
  input wire bit_vld,
  input wire bit_first,
  input wire bit_in,
  input wire invert,
  input wire alarm,
  output reg [7:0] byte_out,
  output reg byte_vld
);

  reg [6:0] sh_r;   // Bits gathered so far, oldest highest.
  reg [2:0] cnt_r;  // Bits gathered so far.
  wire b;           // The bit after inversion and alarm forcing.
  wire [2:0] cnt_use;

  // Line alarms force ones so no false identifier is learned.
  assign b = alarm ? 1'b1 : (bit_in ^ invert);
  // A byte start mark realigns the count, which limits slips to one byte.
  assign cnt_use = bit_first ? 3'h0 : cnt_r;

  // Assemble bytes with the first received bit in byte bit 7.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sh_r <= 7'h00;
      cnt_r <= 3'h0;
      byte_out <= 8'h00;
      byte_vld <= 1'b0;
    end else begin
      byte_vld <= 1'b0;
      if (bit_vld) begin
        sh_r <= {sh_r[5:0], b};
        if (cnt_use == 3'h7) begin
          byte_out <= {sh_r, b};
          byte_vld <= 1'b1;
          cnt_r <= 3'h0;
        end else begin
          cnt_r <= cnt_use + 3'h1;
        end
      end
    end
  end

endmodule // ttc_rx_deser

// File: bench/ttc_top_props.sv
// Port checker of the trail trace controller.
// Assumes one clock and the asynchronous active-low reset of ttc_top.
`timescale 1ns/1ps

module ttc_props (
  input wire clk,
  input wire rstn,
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire tx_bit_req,
  input wire tx_bit,
  input wire rx_bit_vld,
  input wire rx_bit_first,
  input wire rx_bit,
  input wire rx_line_alarm,
  input wire trace_idle,
  input wire trace_unstable_cond,
  input wire trace_mismatch_cond
);
  // Received bits since reset; a verdict needs whole identifiers first.
  reg [10:0] bits_r;
  // Transfers taken by the slave on this edge.
  wire rd_take = hsel && hready && htrans[1] && !hwrite;
  wire wr_take = hsel && hready && htrans[1] && hwrite;

  // The count saturates so that long runs never wrap it back to zero.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bits_r <= 11'h000;
    end else if (rx_bit_vld && bits_r != 11'h7ff) begin
      bits_r <= bits_r + 11'h001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_resp_okay: assert property (
    hresp == 1'b0) else $error("bus response not okay");
  a_read_wait: assert property (
    rd_take |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
  a_write_nowait: assert property (
    wr_take |=> hreadyout) else $error("write stalled");
  a_wait_cause: assert property (
    !hreadyout |-> $past(rd_take)) else $error("stall without read");
  a_rdata_hold: assert property (
    $changed(hrdata) |-> !$past(hreadyout)) else $error("hrdata moved");
  a_tx_hold: assert property (
    !tx_bit_req |=> $stable(tx_bit)) else $error("tx bit moved");
  a_cond_excl: assert property (
    !(trace_idle && trace_unstable_cond)) else $error("idle and unstable");
  a_idle_late: assert property (
    trace_idle |-> bits_r >= 11'h280) else $error("idle too early");
  a_unst_late: assert property (
    trace_unstable_cond |-> bits_r >= 11'h400) else $error("unstable early");
  a_mm_late: assert property (
    trace_mismatch_cond |-> bits_r >= 11'h280) else $error("mismatch early");
endmodule // ttc_props

bind ttc_top ttc_props u_props (.clk(clk), .rstn(rstn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
  .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .tx_bit_req(tx_bit_req),
  .tx_bit(tx_bit), .rx_bit_vld(rx_bit_vld), .rx_bit_first(rx_bit_first),
  .rx_bit(rx_bit), .rx_line_alarm(rx_line_alarm), .trace_idle(trace_idle),
  .trace_unstable_cond(trace_unstable_cond),
  .trace_mismatch_cond(trace_mismatch_cond));

// File: bench/ttc_line_model.sv
// Line-side model of the framer overhead stream.
// Assumes the block's clock; sends trace bytes first bit first.
`timescale 1ns/1ps

module ttc_line_model (
  input wire clk,
  input wire tx_bit,
  output reg tx_bit_req,
  output reg rx_bit_vld,
  output reg rx_bit_first,
  output reg rx_bit
);
  // Quiet line at time zero.
  initial begin
    tx_bit_req = 1'b0;
    rx_bit_vld = 1'b0;
    rx_bit_first = 1'b0;
    rx_bit = 1'b0;
  end

  // A slow byte leaves a gap after each bit showing the inverted bit,
  // so a stale line value can never pass for valid data.
  task send_byte(input [7:0] v, input slow);
    integer j;
    for (j = 7; j >= 0; j = j - 1) begin
      @(posedge clk);
      rx_bit_vld <= 1'b1;
      rx_bit_first <= (j == 7);
      rx_bit <= v[j];
      if (slow) begin
        @(posedge clk);
        rx_bit_vld <= 1'b0;
        rx_bit_first <= 1'b0;
        rx_bit <= ~v[j];
      end
    end
  endtask

  // Whole identifiers, byte 0 first, then the line is released.
  task send_id(input [127:0] v, input integer reps, input slow);
    integer r;
    integer k;
    for (r = 0; r < reps; r = r + 1) begin
      for (k = 0; k < 16; k = k + 1) begin
        send_byte(v[127-8*k -: 8], slow);
      end
    end
    @(posedge clk);
    rx_bit_vld <= 1'b0;
    rx_bit_first <= 1'b0;
    rx_bit <= ~rx_bit;
  endtask

  // One request per bit; the first bit lands in bit 7.
  task tx_byte(output [7:0] v);
    integer j;
    for (j = 0; j < 8; j = j + 1) begin
      @(posedge clk);
      tx_bit_req <= 1'b1;
      @(posedge clk);
      tx_bit_req <= 1'b0;
      repeat (2) @(posedge clk);
      v = {v[6:0], tx_bit};
    end
  endtask
endmodule // ttc_line_model

// File: bench/testbench.sv
// Self-checking bench of the trail trace controller.
// Drives the AHB-Lite port itself; the line model plays the framer.
`timescale 1ns/1ps
`include "ttc_consts.vh"

module testbench;
  reg clk, rstn, hsel, hwrite, rx_line_alarm;
  reg [11:0] haddr;
  reg [1:0] htrans;
  reg [2:0] hsize;
  reg [31:0] hwdata, rd;
  wire [31:0] hrdata;
  wire hreadyout, hresp, tx_bit_req, tx_bit, rx_bit_vld, rx_bit_first;
  wire rx_bit, trace_idle, trace_unstable_cond, trace_mismatch_cond;
  integer num_errors, checks, cyc, i, k;
  reg [7:0] b, e8;
  reg [127:0] id_t, id_i, id_j, id_e;
  // Transmit rows: control word, then the first two bytes on the wire.
  reg [23:0] rows [0:5];

  ttc_top u_dut (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .tx_bit_req(tx_bit_req), .tx_bit(tx_bit),
    .rx_bit_vld(rx_bit_vld), .rx_bit_first(rx_bit_first), .rx_bit(rx_bit),
    .rx_line_alarm(rx_line_alarm), .trace_idle(trace_idle),
    .trace_unstable_cond(trace_unstable_cond),
    .trace_mismatch_cond(trace_mismatch_cond));
  ttc_line_model u_line (.clk(clk), .tx_bit(tx_bit),
    .tx_bit_req(tx_bit_req), .rx_bit_vld(rx_bit_vld),
    .rx_bit_first(rx_bit_first), .rx_bit(rx_bit));

  // Identifier with a chosen first byte and an ascending fill.
  function [127:0] mkid(input [7:0] b0, input [7:0] fill);
    integer n;
    mkid[127:120] = b0;
    for (n = 1; n < 16; n = n + 1) begin
      mkid[127-8*n -: 8] = fill + n[7:0];
    end
  endfunction
  // Byte address of entry n of a 16-word region.
  function [11:0] ad(input [11:0] base, input integer n);
    ad = base + {n[9:0], 2'b00};
  endfunction

  // Compare and count; mismatches are reported at once.
  task chk(input string nm, input [31:0] exp, input [31:0] got);
    checks = checks + 1;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", nm, exp, got);
      num_errors = num_errors + 1;
    end
  endtask
  // One single transfer; the slave's hreadyout is the bus's hready.
  task bus(input w, input [11:0] a, input [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    // Ready is looked at mid-cycle, where it is settled for the next edge.
    @(negedge clk);
    while (hreadyout !== 1'b1) @(negedge clk);
    @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(negedge clk);
    while (hreadyout !== 1'b1) @(negedge clk);
    rd = hrdata;
    @(posedge clk);
  endtask
  task rdc(input string nm, input [11:0] a, input [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask
  // Condition outputs settle a few edges after the last stored byte.
  task cnd(input [2:0] exp);
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("conditions", {29'h0, exp},
      {29'h0, trace_mismatch_cond, trace_unstable_cond, trace_idle});
  endtask
  task end_of_test;
    if (num_errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // A hang is cut short well beyond the expected run length.
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      num_errors = num_errors + 1;
      end_of_test;
    end
  end

  initial begin
    num_errors = 0;
    checks = 0;
    cyc = 0;
    rstn = 1'b0;
    hsel = 1'b0;
    haddr = 12'h000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    rx_line_alarm = 1'b0;
    rows[0] = {8'h00, 8'h35, 8'hc6};
    rows[1] = {8'h01, 8'hac, 8'h63};
    rows[2] = {8'h02, 8'hb5, 8'h46};
    rows[3] = {8'h06, 8'h4a, 8'hb9};
    rows[4] = {8'h07, 8'h53, 8'h9c};
    rows[5] = {8'h0e, 8'h00, 8'h00};
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    // Reset values, an unmapped word and a read-only word.
    rdc("ctrl", `TTC_A_CTRL, 32'h0);
    rdc("status", `TTC_A_STAT, 32'h0);
    bus(1'b1, 12'h008, 32'hffffffff);
    rdc("unmapped", 12'h008, 32'h0);
    bus(1'b1, 12'h080, 32'h000000ff);
    rdc("cur", 12'h080, 32'h0);
    id_t = mkid(8'h35, 8'hc5);
    for (k = 0; k < 16; k = k + 1) begin
      bus(1'b1, ad(12'h040, k), {24'h0, id_t[127-8*k -: 8]});
    end
    // Each row sends one whole identifier; the first two bytes are judged.
    for (i = 0; i < 6; i = i + 1) begin
      bus(1'b1, `TTC_A_CTRL, {24'h0, rows[i][23:16]});
      for (k = 0; k < 16; k = k + 1) begin
        u_line.tx_byte(b);
        e8 = (k == 0) ? rows[i][15:8] : rows[i][7:0];
        if (k < 2) chk("tx", {24'h0, e8}, {24'h0, b});
      end
    end
    // Transmit storage survives a reset.
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rdc("tx", 12'h044, 32'h000000c6);
    // Inverted line: zeros give idle, distinct ids unstable, zeros again.
    bus(1'b1, `TTC_A_CTRL, 32'h10);
    u_line.send_id(~128'h0, 5, 1'b0);
    cnd(3'b001);
    for (i = 0; i < 8; i = i + 1) begin
      u_line.send_id(~mkid(8'h01 + i[7:0], 8'h20), 1, i[0]);
    end
    cnd(3'b010);
    u_line.send_id(~128'h0, 5, 1'b0);
    cnd(3'b001);
    // A line alarm forces received data to ones.
    bus(1'b1, `TTC_A_CTRL, 32'h0);
    rx_line_alarm <= 1'b1;
    u_line.send_id(128'h0, 1, 1'b1);
    rdc("cur", 12'h080, 32'hff);
    rdc("cur", 12'h0bc, 32'hff);
    rx_line_alarm <= 1'b0;
    bus(1'b1, `TTC_A_CTRL, 32'h40);
    u_line.send_id(mkid(8'h3c, 8'h1d), 1, 1'b0);
    rdc("cur", 12'h084, 32'h78);
    // Aligned receive with comparison against a programmed identifier.
    id_i = mkid(8'hc1, 8'h40);
    id_j = id_i ^ {40'h0, 8'h01, 80'h0};
    id_e = id_i ^ {24'h0, 8'h80, 96'h0};
    for (k = 0; k < 16; k = k + 1) begin
      bus(1'b1, ad(12'h100, k), {24'h0, id_e[127-8*k -: 8]});
    end
    rdc("exp", 12'h10c, {24'h0, id_e[103:96]});
    bus(1'b1, `TTC_A_CTRL, 32'ha0);
    for (i = 0; i < 3; i = i + 1) begin
      u_line.send_byte(8'h11, 1'b0);
    end
    u_line.send_id(id_j, 4, 1'b1);
    cnd(3'b000);
    bus(1'b1, `TTC_A_CTRL, 32'h20);
    u_line.send_id(id_j, 1, 1'b0);
    cnd(3'b000);
    bus(1'b1, `TTC_A_CTRL, 32'ha0);
    u_line.send_id(id_i, 5, 1'b0);
    cnd(3'b000);
    rdc("status", `TTC_A_STAT, 32'h38);
    for (k = 0; k < 16; k = k + 1) begin
      rdc("rcv", ad(12'h0c0, k), {24'h0, id_i[127-8*k -: 8]});
    end
    u_line.send_id(id_j, 5, 1'b0);
    cnd(3'b100);
    bus(1'b1, `TTC_A_STAT, 32'h20);
    rdc("status", `TTC_A_STAT, 32'h1c);
    end_of_test;
  end
endmodule // testbench
